//--- supply_supervisor_watchdog.sv
// Supply supervisor core: reset pulse, flags, watchdog, chip-enable gating, APB registers
// Operation
// - Power-fail flag follows the power-fail comparator: high above reference, low below.
// - Active-low reset asserted when supply is under threshold or under backup.
// - After recovery reset stays asserted the reset active time, 35 or 140 ms minimum.
// - Unserviced enabled watchdog gives one reset pulse every timeout period.
// - Active-high reset is always the inverse of active-low reset.
// - Low-supply flag low below threshold, high again at once above it.
// - Low-supply flag also low while supply is below backup.
// - Kick input is three-level; floating it disables the watchdog.
// - Kick steady beyond timeout drives reset and expiry output low.
// - Every kick edge restarts the watchdog; host must toggle within the period.
// - Expiry output set high on any kick edge or when low-supply falls.
// - Above threshold the gated chip enable copies the chip-enable input.
// - Below threshold the gated chip enable is held high.
// - Select high or floating: internal oscillator times reset and watchdog.
// - Select low: external clock on timebase input, times set by counts.
// - Internal oscillator reset time 50 ms short variant, 200 ms long.
// - Internal oscillator: timebase input level picks 1.6 s or 100 ms timeout.
// - First watchdog timeout after any reset is always the long period.
// - Switchover comparator picks main or backup; backup-active shows it.
// - In backup mode inputs ignored and outputs forced to fixed levels.
// - External clock divided by 64 before it clocks the timers.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator results
  input wire logic supply_threshold_comparator,
  input wire logic switchover_comparator,
  input wire logic fail_warning_comparator,
  // Watchdog kick: level and float detect of the three-level pin
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  // Timebase pins
  input wire logic timebase_source_select,
  input wire logic timebase_input,
  // Memory chip enable
  input wire logic chip_enable_in_n,
  output logic chip_enable_out_n,
  // Supervisor outputs
  output logic reset_n,
  output logic reset_out,
  output logic low_supply_n,
  output logic power_fail_flag_n,
  output logic watchdog_expired_n,
  output logic backup_active
);
  // Synchronised pin levels
  logic [7:0] pins_raw;
  logic [7:0] pins_s;
  logic sup_s;
  logic main_s;
  logic pf_s;
  logic kick_s;
  logic kfl_s;
  logic tsel_s;
  logic tin_s;
  logic cein_s;

  // Registers
  supervisor_pkg::sup_state_t state_r;
  supervisor_pkg::sup_state_t state_nxt;
  logic long_r;
  logic [15:0] ext_rst_r;
  logic [15:0] ext_wd_r;
  logic [31:0] prdata_r;
  logic [15:0] tick_cnt_r;
  logic [5:0] div_cnt_r;
  logic tin_d_r;
  logic kick_d_r;
  logic [15:0] pulse_cnt_r;
  logic [15:0] wd_cnt_r;
  logic first_r;
  logic wdo_r;
  logic reset_n_r;
  logic low_n_r;
  logic pf_n_r;
  logic ce_out_r;

  // Decode and combinational terms
  logic supply_good;
  logic backup;
  logic int_tick;
  logic ext_tick;
  logic tick;
  logic [15:0] rst_ticks;
  logic [15:0] wd_sel_ticks;
  logic [15:0] wd_ticks;
  logic wd_enabled;
  logic kick_edge;
  logic pulse_done;
  logic wd_timeout;
  logic low_fall;
  logic apb_access;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_rst;
  logic hit_wd;
  logic hit_st;
  logic addr_bad;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // All outside levels pass two flops before use
  assign pins_raw = {chip_enable_in_n, timebase_input, timebase_source_select,
                     watchdog_kick_float, watchdog_kick_in, fail_warning_comparator,
                     switchover_comparator, supply_threshold_comparator};

  sync_stage #(
    .WIDTH(8)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign sup_s = pins_s[0];
  assign main_s = pins_s[1];
  assign pf_s = pins_s[2];
  assign kick_s = pins_s[3];
  assign kfl_s = pins_s[4];
  assign tsel_s = pins_s[5];
  assign tin_s = pins_s[6];
  assign cein_s = pins_s[7];

  // Supply qualification; comparator carries the 70/50 mV hysteresis itself
  assign backup = !main_s;
  assign supply_good = sup_s && !backup;

  // Timebase: internal 1 ms tick, or external clock divided by 64
  assign int_tick = tick_cnt_r == 16'(TICK_CYCLES - 1);
  assign ext_tick = tin_s && !tin_d_r && div_cnt_r == supervisor_pkg::EXT_DIV_LAST;
  assign tick = tsel_s ? int_tick : ext_tick;

  // Period selection; the first timeout after any reset is the long one
  assign rst_ticks = !tsel_s ? ext_rst_r :
                     long_r ? supervisor_pkg::RST_LONG_TICKS :
                     supervisor_pkg::RST_SHORT_TICKS;
  assign wd_sel_ticks = !tsel_s ? ext_wd_r :
                        tin_s ? supervisor_pkg::WD_LONG_TICKS :
                        supervisor_pkg::WD_SHORT_TICKS;
  assign wd_ticks = first_r ? supervisor_pkg::WD_LONG_TICKS : wd_sel_ticks;

  // Watchdog runs only with the pin driven and the supply good
  assign wd_enabled = !kfl_s && supply_good;
  assign kick_edge = wd_enabled && (kick_s != kick_d_r);
  assign pulse_done = tick && (pulse_cnt_r + 16'h0001 >= rst_ticks);
  assign wd_timeout = (state_r == supervisor_pkg::ST_RUN) && wd_enabled && !kick_edge
                      && tick && (wd_cnt_r + 16'h0001 >= wd_ticks);
  assign low_fall = low_n_r && !supply_good;

  // Reset pulse generator
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      supervisor_pkg::ST_HOLD:
        if (supply_good)
          state_nxt = supervisor_pkg::ST_PULSE;
      supervisor_pkg::ST_PULSE:
        if (!supply_good)
          state_nxt = supervisor_pkg::ST_HOLD;
        else if (pulse_done)
          state_nxt = supervisor_pkg::ST_RUN;
      supervisor_pkg::ST_RUN:
        if (!supply_good)
          state_nxt = supervisor_pkg::ST_HOLD;
        else if (wd_timeout)
          state_nxt = supervisor_pkg::ST_PULSE;
      default:
        state_nxt = supervisor_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= supervisor_pkg::ST_HOLD;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // Timebase counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 16'h0000;
      div_cnt_r <= 6'h00;
      tin_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_cnt_r <= int_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      tin_d_r <= tin_s;
      if (tin_s && !tin_d_r)
        div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // Reset active timer; restarts whenever the pulse begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt_r <= 16'h0000;
    else if (clk_en)
    begin
      if (state_r != supervisor_pkg::ST_PULSE)
        pulse_cnt_r <= 16'h0000;
      else if (tick)
        pulse_cnt_r <= pulse_cnt_r + 16'h0001;
    end
  end

  // Watchdog counter and first-period flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cnt_r <= 16'h0000;
      first_r <= 1'b1;
      kick_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      kick_d_r <= kick_s;
      if (state_r != supervisor_pkg::ST_RUN || !wd_enabled || kick_edge || wd_timeout)
        wd_cnt_r <= 16'h0000;
      else if (tick)
        wd_cnt_r <= wd_cnt_r + 16'h0001;
      if (state_r != supervisor_pkg::ST_RUN)
        first_r <= 1'b1;
      else if (kick_edge)
        first_r <= 1'b0;
    end
  end

  // Expiry output: set (edge, low-supply fall or backup) wins over the timeout clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdo_r <= 1'b1;
    else if (clk_en)
    begin
      if (kick_edge || low_fall || backup)
        wdo_r <= 1'b1;
      else if (wd_timeout)
        wdo_r <= 1'b0;
    end
  end

  // Output flags, registered so they never glitch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_n_r <= 1'b0;
      low_n_r <= 1'b0;
      pf_n_r <= 1'b0;
      ce_out_r <= 1'b1;
    end
    else if (clk_en)
    begin
      reset_n_r <= (state_nxt == supervisor_pkg::ST_RUN) && supply_good;
      low_n_r <= supply_good;
      pf_n_r <= pf_s && !backup;
      ce_out_r <= supply_good ? cein_s : 1'b1;
    end
  end

  assign reset_n = reset_n_r;
  assign reset_out = !reset_n_r;
  assign low_supply_n = low_n_r;
  assign power_fail_flag_n = pf_n_r;
  assign watchdog_expired_n = wdo_r;
  assign chip_enable_out_n = ce_out_r;
  assign backup_active = backup;

  // APB decode; zero wait states, error on unmapped or read-only write
  assign apb_access = psel && penable;
  assign hit_ctrl = paddr == supervisor_pkg::CTRL_OFF;
  assign hit_rst = paddr == supervisor_pkg::EXT_RST_OFF;
  assign hit_wd = paddr == supervisor_pkg::EXT_WD_OFF;
  assign hit_st = paddr == supervisor_pkg::STATUS_OFF;
  assign addr_bad = !(hit_ctrl || hit_rst || hit_wd || (hit_st && !pwrite));
  assign apb_wr = apb_access && pwrite && !addr_bad;
  assign pready = 1'b1;
  assign pslverr = apb_access && addr_bad;

  assign status_word = {25'h0000000, first_r, wd_enabled, backup, wdo_r, pf_n_r,
                        low_n_r, reset_n_r};
  assign rd_word = hit_ctrl ? {31'h00000000, long_r} :
                   hit_rst ? {16'h0000, ext_rst_r} :
                   hit_wd ? {16'h0000, ext_wd_r} :
                   hit_st ? status_word : 32'h00000000;
  assign prdata = prdata_r;

  // Register writes and read data capture during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      long_r <= supervisor_pkg::CTRL_LONG_RST;
      ext_rst_r <= supervisor_pkg::EXT_RST_RST;
      ext_wd_r <= supervisor_pkg::EXT_WD_RST;
      prdata_r <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (apb_wr && hit_ctrl)
        long_r <= pwdata[supervisor_pkg::CTRL_LONG_BIT];
      if (apb_wr && hit_rst)
        ext_rst_r <= pwdata[15:0];
      if (apb_wr && hit_wd)
        ext_wd_r <= pwdata[15:0];
      if (psel && !penable && !pwrite)
        prdata_r <= rd_word;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);
  a_reset_inverse: assert property (reset_out == !reset_n)
    else $error("active-high reset not inverse of reset_n");
  a_reset_on_low: assert property ($past(clk_en) && !$past(supply_good) |-> !reset_n)
    else $error("reset released with supply bad");
  a_pf_follow: assert property ($past(clk_en) |->
    power_fail_flag_n == ($past(pf_s) && !$past(backup)))
    else $error("power-fail flag wrong");
  a_low_follow: assert property ($past(clk_en) |-> low_supply_n == $past(supply_good))
    else $error("low-supply flag wrong");
  a_ce_block: assert property (!supply_good ##1 $past(clk_en) |-> chip_enable_out_n)
    else $error("chip enable not blocked");
  a_timeout_low: assert property (wd_timeout ##1 clk_en |-> !watchdog_expired_n && !reset_n)
    else $error("timeout did not drive outputs low");
  a_pulse_entry: assert property (state_r == supervisor_pkg::ST_PULSE |-> !reset_n)
    else $error("reset high during pulse");
  a_kick_sets_wdo: assert property (kick_edge ##1 $past(clk_en) |-> watchdog_expired_n)
    else $error("kick edge did not set expiry high");
  a_backup_levels: assert property (backup ##1 $past(clk_en) |->
    !reset_n && !low_supply_n && !power_fail_flag_n && watchdog_expired_n && chip_enable_out_n)
    else $error("backup mode levels wrong");
  a_float_disables: assert property (kfl_s |-> !wd_timeout)
    else $error("watchdog timed out while floating");
  c_power_up: cover property (state_r == supervisor_pkg::ST_PULSE ##1 state_r == supervisor_pkg::ST_RUN);
  c_wd_timeout: cover property (wd_timeout);
  c_backup: cover property (backup ##1 !backup);
endmodule
`default_nettype wire

//--- supervisor_pkg.sv
// Shared constants for the supply supervisor and watchdog core
package supervisor_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] EXT_RST_OFF = 8'h04;
  localparam logic [7:0] EXT_WD_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  // Field positions
  localparam int CTRL_LONG_BIT = 0;
  localparam int ST_RESET_BIT = 0;
  localparam int ST_LOW_BIT = 1;
  localparam int ST_PF_BIT = 2;
  localparam int ST_WDO_BIT = 3;
  localparam int ST_BACKUP_BIT = 4;
  localparam int ST_WDEN_BIT = 5;
  localparam int ST_FIRST_BIT = 6;
  // Reset values
  localparam logic CTRL_LONG_RST = 1'b0;
  localparam logic [15:0] EXT_RST_RST = 16'h0032;
  localparam logic [15:0] EXT_WD_RST = 16'h0064;
  // Timing: clock rate and one internal-oscillator tick
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  // Typical times in ms, counted in 1 ms ticks
  localparam int RST_SHORT_MS = 50;
  localparam int RST_LONG_MS = 200;
  localparam int WD_LONG_MS = 1600;
  localparam int WD_SHORT_MS = 100;
  localparam logic [15:0] RST_SHORT_TICKS = 16'(RST_SHORT_MS * 1000 / TICK_US);
  localparam logic [15:0] RST_LONG_TICKS = 16'(RST_LONG_MS * 1000 / TICK_US);
  localparam logic [15:0] WD_LONG_TICKS = 16'(WD_LONG_MS * 1000 / TICK_US);
  localparam logic [15:0] WD_SHORT_TICKS = 16'(WD_SHORT_MS * 1000 / TICK_US);
  // Last divider count: external clock is divided by 64 before it times anything
  localparam logic [5:0] EXT_DIV_LAST = 6'h3F;
  // Supervisor states, one-hot
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_PULSE = 3'b010,
    ST_RUN = 3'b100
  } sup_state_t;
endpackage

//--- sync_stage.sv
// Two-flop synchroniser for a vector of unrelated pin levels
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- host_model.sv
// Host side model: drives the watchdog kick pin
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int HALF = 200
) (
  // Clock
  input wire logic pclk,
  // Control
  input wire logic kick_run,
  // Kick pin level
  output var logic kick
);
  int cnt = 0;
  initial kick = 1'b0;
  // Toggle well inside the short timeout; a stopped host holds its level
  always @(posedge pclk)
  begin
    if (kick_run && cnt >= HALF - 1)
    begin
      kick <= ~kick;
      cnt <= 0;
    end
    else
      cnt <= kick_run ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

//--- supply_supervisor_watchdog_tb.sv
// Self-checking bench for the supply supervisor core
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, supply = 1'b0, swo = 1'b1, fail = 1'b1, kick;
  logic kfloat = 1'b1, tsel = 1'b1, tin = 1'b1, ce_in = 1'b1, kick_run = 1'b0, en = 1'b1;
  logic ce_out, reset_n, reset_out, low_n, pf_n, wdo_n, bk;
  int n_errors = 0, checked = 0, n;
  // Small tick so 1 ms is 10 cycles
  supply_supervisor_watchdog #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn),
    .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_threshold_comparator(supply), .switchover_comparator(swo),
    .fail_warning_comparator(fail), .watchdog_kick_in(kick), .watchdog_kick_float(kfloat),
    .timebase_source_select(tsel), .timebase_input(tin), .chip_enable_in_n(ce_in),
    .chip_enable_out_n(ce_out), .reset_n(reset_n), .reset_out(reset_out),
    .low_supply_n(low_n), .power_fail_flag_n(pf_n), .watchdog_expired_n(wdo_n),
    .backup_active(bk));
  host_model #(.HALF(200)) host (.pclk(pclk), .kick_run(kick_run), .kick(kick));
  always #10 pclk = ~pclk;
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Range check of a cycle count against the expected window
  task rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("MISMATCH t=%0t count=%h window=%h..%h", $time, got, lo, hi);
    end
  endtask
  // One APB transfer; held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the run watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task t_regs;
    apb(1'b0, supervisor_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, supervisor_pkg::EXT_RST_OFF, 32'h0);
    chk(rd, 32'h0000_0032);
    apb(1'b0, supervisor_pkg::EXT_WD_OFF, 32'h0);
    chk(rd, 32'h0000_0064);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, supervisor_pkg::STATUS_OFF, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, supervisor_pkg::CTRL_OFF, 32'h1);
    apb(1'b0, supervisor_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
  endtask
  // Power up with the long variant selected: 200 ticks
  task t_powerup;
    supply <= 1'b1;
    wait_cyc(5);
    chk({low_n, reset_n, reset_out}, 32'h5);
    n = 5;
    while (reset_n !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    rng(n, 1995, 2030);
    chk({30'h0, reset_n, reset_out}, 32'h2);
    apb(1'b0, supervisor_pkg::STATUS_OFF, 32'h0);
    chk(rd, 32'h0000_004F);
  endtask
  task t_flags;
    fail <= 1'b0;
    ce_in <= 1'b0;
    wait_cyc(5);
    chk({pf_n, ce_out}, 32'h0);
    fail <= 1'b1;
    ce_in <= 1'b1;
    wait_cyc(5);
    chk({pf_n, ce_out}, 32'h3);
  endtask
  // Supply dip, then recovery with the short variant
  task t_dip;
    apb(1'b1, supervisor_pkg::CTRL_OFF, 32'h0);
    ce_in <= 1'b0;
    supply <= 1'b0;
    en <= 1'b0;
    wait_cyc(10);
    chk({30'h0, reset_n, low_n}, 32'h3); // Frozen core keeps its flags
    en <= 1'b1;
    wait_cyc(5);
    chk({reset_n, low_n, ce_out, wdo_n}, 32'h3);
    supply <= 1'b1;
    n = 0;
    while (reset_n !== 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    rng(n, 495, 530);
  endtask
  task t_watchdog;
    tin <= 1'b0;
    kfloat <= 1'b0;
    n = 0;
    while (wdo_n !== 1'b0 && n < 17000)
    begin
      @(posedge pclk);
      n++;
    end
    rng(n, 15990, 16040);
    wait_cyc(3);
    chk({reset_n, wdo_n}, 32'h0);
    kick_run <= 1'b1;
    wait_cyc(250);
    chk({31'h0, wdo_n}, 32'h1);
    wait_cyc(3000);
    chk({reset_n, wdo_n}, 32'h3);
    kick_run <= 1'b0;
    n = 0;
    while (wdo_n !== 1'b0 && n < 1500)
    begin
      @(posedge pclk);
      n++;
    end
    rng(n, 790, 1040);
    kick_run <= 1'b1;
    wait_cyc(900);
  endtask
  task t_backup;
    ce_in <= 1'b0;
    fail <= 1'b1;
    swo <= 1'b0;
    wait_cyc(5);
    chk({bk, reset_n, low_n, pf_n, wdo_n, ce_out}, 32'h23);
    swo <= 1'b1;
    wait_cyc(5);
    chk({31'h0, bk}, 32'h0);
  endtask
  // Watchdog on the whole run
  initial
  begin
    #1000000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    wait_cyc(3);
    presetn <= 1'b1;
    t_regs();
    t_powerup();
    t_flags();
    t_dip();
    t_watchdog();
    t_backup();
    report_and_stop();
  end
endmodule
`default_nettype wire
